// ---- src/scd_pkg.sv ----
package scd_pkg;
    // register map, byte offsets on the 8-bit register port
    localparam logic [7:0] DIV_OFFSET    = 8'h95;
    localparam logic [7:0] CFG_OFFSET    = 8'h96;
    localparam logic [7:0] STAT_OFFSET   = 8'h97;
    localparam logic [7:0] DIV_RESET     = 8'h00;
    localparam logic [7:0] CFG_UNPROG    = 8'hFF;
    // clock configuration byte fields
    localparam int         CFG_SRC_LO    = 0;
    localparam int         CFG_RCFS_BIT  = 3;
    localparam int         CFG_FILT_BIT  = 4;
    // status byte fields
    localparam int         STAT_LD_BIT   = 0;
    localparam int         STAT_SRC_LO   = 1;
    localparam int         STAT_RUN_BIT  = 3;
    // rates
    localparam int         REF_CLK_MHZ   = 100;
    localparam int         RC_FULL_KHZ   = 22118;
    localparam int         XTAL_MIN_KHZ  = 4000;
    localparam int         XTAL_MAX_KHZ  = 24000;
    localparam int         FILT_CYCLES   = 2;

    typedef enum logic [1:0] {
        SRC_EXT  = 2'b00,
        SRC_XTAL = 2'b01,
        SRC_RSVD = 2'b10,
        SRC_RC   = 2'b11
    } scd_src_e;
endpackage

// ---- src/scd_clock_select.sv ----
// How it works
// - select field 11 is RC oscillator, 01 crystal, 10 reserved.
// - RC mode with frequency select 1 uses full oscillator rate.
// - RC mode with frequency select 0 halves the oscillator rate.
// - filter enable inserts noise filter on crystal input, else bypass.
// - divisor zero passes source clock through undivided.
// - nonzero divisor N gives source rate over 2 times (N plus 1).
// - divisor register is read/write and resets to zero.
// - unprogrammed configuration byte is all ones: RC, full rate, filter.
//
// Our own choice: the strobed register port.
module scd_clock_select
    import scd_pkg::*;
#(
    parameter int FILT_LEN = FILT_CYCLES
) (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       arst_n,
    // non-volatile configuration bits
    input  wire logic [7:0] cfg_nv,
    // oscillator sources
    input  wire logic       rc_osc_in,
    input  wire logic       xtal_in,
    output logic            xtal_out_o,
    output logic            xtal_out_oe,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_we,
    input  wire logic       reg_re,
    output logic [7:0]      reg_rdata,
    // system clock enable
    output logic            sys_tick
);
    localparam int FW = $clog2(FILT_LEN + 1);

    logic [7:0]    cfg_q;
    logic          ld_done_q;
    logic [7:0]    div_q;
    logic          rc_s1_q, rc_s2_q, xt_s1_q, xt_s2_q;
    logic          xt_flt_q;
    logic [FW-1:0] flt_cnt_q;
    logic          xt_lvl, sel_lvl, prev_q, edge_d;
    logic          half_q, src_tick_d, src_tick_q;
    logic [8:0]    div_cnt_q;
    logic          sys_tick_q;
    logic [7:0]    rdata_q;
    logic          xout_q, xout_oe_q;
    scd_src_e      src_sel;
    logic          rc_mode, rc_full, flt_en;

    assign src_sel     = scd_src_e'(cfg_q[CFG_SRC_LO +: 2]);
    assign rc_mode     = (src_sel == SRC_RC);
    assign rc_full     = cfg_q[CFG_RCFS_BIT];
    assign flt_en      = cfg_q[CFG_FILT_BIT];
    assign sys_tick    = sys_tick_q;
    assign reg_rdata   = rdata_q;
    assign xtal_out_o  = xout_q;
    assign xtal_out_oe = xout_oe_q;

    function automatic logic is_write(input logic [7:0] off);
        return reg_we && (reg_addr == off);
    endfunction

    // configuration byte caught once after reset release
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_q     <= CFG_UNPROG;
            ld_done_q <= 1'b0;
        end else if (!ld_done_q) begin
            cfg_q     <= cfg_nv;
            ld_done_q <= 1'b1;
        end
    end

    // divisor register
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_q <= DIV_RESET;
        end else if (is_write(DIV_OFFSET)) begin
            div_q <= reg_wdata;
        end
    end

    // read data, valid only in the cycle after the strobe
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 8'h00;
        end else if (reg_re) begin
            unique case (reg_addr)
                DIV_OFFSET:  rdata_q <= div_q;
                CFG_OFFSET:  rdata_q <= cfg_q;
                STAT_OFFSET: begin
                    rdata_q <= 8'h00;
                    rdata_q[STAT_LD_BIT]       <= ld_done_q;
                    rdata_q[STAT_SRC_LO +: 2]  <= src_sel;
                    rdata_q[STAT_RUN_BIT]      <= (src_sel != SRC_RSVD);
                end
                default:     rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // pin synchronisers
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rc_s1_q <= 1'b0;
            rc_s2_q <= 1'b0;
            xt_s1_q <= 1'b0;
            xt_s2_q <= 1'b0;
        end else begin
            rc_s1_q <= rc_osc_in;
            rc_s2_q <= rc_s1_q;
            xt_s1_q <= xtal_in;
            xt_s2_q <= xt_s1_q;
        end
    end

    // crystal input filter: level must persist before it is accepted
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            xt_flt_q  <= 1'b0;
            flt_cnt_q <= '0;
        end else if (xt_s2_q == xt_flt_q) begin
            flt_cnt_q <= '0;
        end else if (flt_cnt_q == FW'(FILT_LEN - 1)) begin
            xt_flt_q  <= xt_s2_q;
            flt_cnt_q <= '0;
        end else begin
            flt_cnt_q <= flt_cnt_q + FW'(1);
        end
    end

    // source selection and edge detection
    always_comb begin
        xt_lvl = flt_en ? xt_flt_q : xt_s2_q;
        unique case (src_sel)
            SRC_RC:   sel_lvl = rc_s2_q;
            SRC_XTAL: sel_lvl = xt_lvl;
            SRC_EXT:  sel_lvl = xt_lvl;
            SRC_RSVD: sel_lvl = 1'b0;
        endcase
        edge_d     = sel_lvl && !prev_q;
        src_tick_d = edge_d && (!rc_mode || rc_full || half_q);
    end

    // halving stage for the RC oscillator
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_q     <= 1'b0;
            half_q     <= 1'b0;
            src_tick_q <= 1'b0;
        end else begin
            prev_q     <= sel_lvl;
            src_tick_q <= src_tick_d;
            if (!ld_done_q) begin
                half_q <= 1'b0;
            end else if (edge_d && rc_mode && !rc_full) begin
                half_q <= !half_q;
            end
        end
    end

    // system clock divider
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt_q  <= 9'h000;
            sys_tick_q <= 1'b0;
        end else if (!src_tick_q) begin
            sys_tick_q <= 1'b0;
        end else if (div_q == 8'h00) begin
            div_cnt_q  <= 9'h000;
            sys_tick_q <= 1'b1;
        end else if (div_cnt_q >= {div_q, 1'b1}) begin
            div_cnt_q  <= 9'h000;
            sys_tick_q <= 1'b1;
        end else begin
            div_cnt_q  <= div_cnt_q + 9'h001;
            sys_tick_q <= 1'b0;
        end
    end

    // crystal amplifier drive, off for external clock
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            xout_q    <= 1'b0;
            xout_oe_q <= 1'b0;
        end else begin
            xout_q    <= !xt_s2_q;
            xout_oe_q <= (src_sel == SRC_XTAL);
        end
    end

    // helpers for checks
    logic [1:0]  gap_q;
    logic [9:0]  per_q;
    logic        per_ok_q;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            gap_q    <= 2'h0;
            per_q    <= 10'h000;
            per_ok_q <= 1'b0;
        end else begin
            if (!ld_done_q || src_tick_d) begin
                gap_q <= 2'h0;
            end else if (edge_d && gap_q != 2'h3) begin
                gap_q <= gap_q + 2'h1;
            end
            if (sys_tick_q) begin
                per_q <= {9'h000, src_tick_q};
            end else if (src_tick_q) begin
                per_q <= per_q + 10'h001;
            end
            if (is_write(DIV_OFFSET) || !ld_done_q) begin
                per_ok_q <= 1'b0;
            end else if (sys_tick_q) begin
                per_ok_q <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    property p_rsvd_silent;
        ld_done_q && src_sel == SRC_RSVD |-> !src_tick_d;
    endproperty
    a_rsvd_silent: assert property (p_rsvd_silent)
        else $error("reserved source produced a tick");

    property p_ext_no_amp;
        ld_done_q && src_sel == SRC_EXT |=> !xout_oe_q;
    endproperty
    a_ext_no_amp: assert property (p_ext_no_amp)
        else $error("amplifier driven with external clock");

    property p_rc_full;
        ld_done_q && rc_mode && rc_full && src_tick_d |-> gap_q == 2'h0;
    endproperty
    a_rc_full: assert property (p_rc_full)
        else $error("full rate RC skipped an edge");

    property p_rc_half;
        ld_done_q && rc_mode && !rc_full && src_tick_d |-> gap_q == 2'h1;
    endproperty
    a_rc_half: assert property (p_rc_half)
        else $error("halved RC tick not on every second edge");

    property p_filter;
        flt_en && $changed(xt_flt_q) |->
            $past(xt_s2_q, 1) == xt_flt_q && $past(xt_s2_q, 2) == xt_flt_q;
    endproperty
    a_filter: assert property (p_filter)
        else $error("filter accepted a short glitch");

    property p_undivided;
        div_q == 8'h00 && src_tick_q |=> sys_tick_q;
    endproperty
    a_undivided: assert property (p_undivided)
        else $error("undivided tick missing");

    property p_divided;
        sys_tick_q && per_ok_q && div_q != 8'h00 && $stable(div_q) |->
            per_q == ({2'b00, div_q} + 10'h001) * 10'h002;
    endproperty
    a_divided: assert property (p_divided)
        else $error("divided period wrong");

    property p_div_write;
        reg_we && reg_addr == DIV_OFFSET |=> div_q == $past(reg_wdata);
    endproperty
    a_div_write: assert property (p_div_write)
        else $error("divisor write lost");

    property p_div_read;
        reg_re && reg_addr == DIV_OFFSET |=> reg_rdata == $past(div_q);
    endproperty
    a_div_read: assert property (p_div_read)
        else $error("divisor readback wrong");

    property p_cfg_hold;
        ld_done_q |=> $stable(cfg_q);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold)
        else $error("configuration byte changed after load");
endmodule

// ---- verification/scd_osc_model.sv ----
module scd_osc_model (
    // enables
    input  wire logic rc_en,
    input  wire logic x_en,
    // commanded glitch on the crystal input
    input  wire logic glitch,
    // source lines
    output logic      rc_osc_in,
    output logic      xtal_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // half periods in ns, edges kept 2 ns off the sampling edge
    localparam int RC_HALF = 30;
    localparam int X_HALF  = 50;

    logic rc_q;
    logic x_q;

    initial begin
        rc_q = 1'b0;
        #3;
        forever #RC_HALF rc_q = ~rc_q;
    end

    // 10 MHz crystal, inside the allowed range
    initial begin
        x_q = 1'b0;
        #3;
        forever #X_HALF x_q = ~x_q;
    end

    // stopped sources stand still low
    assign rc_osc_in = rc_en & rc_q;
    assign xtal_in   = (x_en & x_q) | glitch;
endmodule

// ---- verification/system_clock_select_divider_tb.sv ----
module system_clock_select_divider_tb import scd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int RP = 6;
    localparam int XP = 10;

    logic       ref_clk, arst_n, rc_en, x_en, glitch, reg_we, reg_re;
    logic       rc_osc, xtal, xtal_out_o, xtal_out_oe, sys_tick, re_d;
    logic [7:0] cfg_nv, reg_addr, reg_wdata, reg_rdata, c;
    logic [7:0] exp_q[$];
    int         bad_count, n_compared, iv, n;
    logic [7:0] cfgs[4] = '{8'hF7, 8'hFD, 8'hEC, 8'hFE};
    int         ivs[4]  = '{2 * RP, XP, XP, 0};
    logic       oes[4]  = '{1'b0, 1'b1, 1'b0, 1'b0};
    logic [7:0] dvs[3];

    scd_osc_model u_osc (.rc_en(rc_en), .x_en(x_en), .glitch(glitch),
                         .rc_osc_in(rc_osc), .xtal_in(xtal));

    scd_clock_select #(.FILT_LEN(2)) uut (
        .ref_clk(ref_clk), .arst_n(arst_n), .cfg_nv(cfg_nv),
        .rc_osc_in(rc_osc), .xtal_in(xtal), .xtal_out_o(xtal_out_o),
        .xtal_out_oe(xtal_out_oe), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
        .reg_rdata(reg_rdata), .sys_tick(sys_tick));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // read data stand in the cycle after the strobe
    always @(posedge ref_clk) begin
        if (re_d === 1'b1)
            chk("rdata", {8'h00, exp_q.pop_front()}, {8'h00, reg_rdata});
        re_d <= reg_re;
    end

    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge ref_clk);
        reg_re <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge ref_clk);
        reg_re <= 1'b0;
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge ref_clk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_we <= 1'b0;
    endtask

    task automatic rst(logic [7:0] cf);
        @(posedge ref_clk);
        arst_n <= 1'b0;
        cfg_nv <= cf;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (10) @(posedge ref_clk);
    endtask

    // cycles between the second and third tick, 0 if none
    task automatic meas(int lim, output int r);
        int cnt, k, t2;
        cnt = 0;
        k = 0;
        t2 = 0;
        r = 0;
        while (k < 3 && cnt < lim) begin
            @(negedge ref_clk);
            cnt++;
            if (sys_tick === 1'b1) begin
                k++;
                if (k == 2) t2 = cnt;
                if (k == 3) r = cnt - t2;
            end
        end
    endtask

    initial begin
        arst_n = 1'b0;
        cfg_nv = CFG_UNPROG;
        {reg_we, reg_re, glitch} = 3'h0;
        {reg_addr, reg_wdata} = 16'h0000;
        rc_en = 1'b1;
        x_en = 1'b1;
        bad_count = 0;
        n_compared = 0;
        n = $urandom(89165);
        repeat (16) @(posedge ref_clk);
        arst_n <= 1'b1;
        rd(DIV_OFFSET, DIV_RESET);
        rd(CFG_OFFSET, CFG_UNPROG);
        wr(CFG_OFFSET, 8'h00);
        rd(CFG_OFFSET, CFG_UNPROG);
        rd(8'h10, 8'h00);
        meas(1000, iv);
        chk("iv_rc_full", 16'(RP), 16'(iv));
        $display("test registers and default source done");
        dvs = '{8'h01, 8'hFF, 8'h02 + 8'($urandom % 40)};
        foreach (dvs[i]) begin
            wr(DIV_OFFSET, dvs[i]);
            rd(DIV_OFFSET, dvs[i]);
            meas(10000, iv);
            chk("iv_div", 16'(2 * (dvs[i] + 1) * RP), 16'(iv));
        end
        $display("test divisor done");
        foreach (cfgs[i]) begin
            c = cfgs[i];
            rst(c);
            rd(DIV_OFFSET, DIV_RESET);
            rd(CFG_OFFSET, c);
            rd(STAT_OFFSET, {4'h0, c[1:0] != 2'b10, c[1:0], 1'b1});
            meas(1000, iv);
            chk("iv_src", 16'(ivs[i]), 16'(iv));
            chk("xtal_oe", {15'h0000, oes[i]}, {15'h0000, xtal_out_oe});
        end
        $display("test source select done");
        x_en = 1'b0;
        for (int f = 0; f < 2; f++) begin
            rst(f == 1 ? 8'hFC : 8'hEC);
            chk("xtal_out", 16'h0001, {15'h0000, xtal_out_o});
            @(posedge ref_clk);
            glitch <= 1'b1;
            @(posedge ref_clk);
            glitch <= 1'b0;
            n = 0;
            repeat (20) begin
                @(negedge ref_clk);
                if (sys_tick === 1'b1) n++;
            end
            chk("glitch_ticks", 16'((f == 1) ? 0 : 1), 16'(n));
        end
        $display("test input filter done");
        finish_test();
    end

    initial begin
        #300000;
        bad_count++;
        finish_test();
    end
endmodule
